// ---- pasd_pkg.sv ----
package pasd_pkg;

    // Register byte addresses on the AXI4-Lite port.
    localparam int              ADDR_W        = 8;
    localparam logic [ADDR_W-1:0] OFF_DEADBAND  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SHUTDOWN  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MODE      = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_MASK     = 8'hf3;

    // Reset values of the software registers.
    localparam logic [7:0]      RST_DEADBAND  = 8'h00;
    localparam logic [7:0]      RST_SHUTDOWN  = 8'h00;
    localparam logic [7:0]      RST_MODE      = 8'h00;

    // Output configurations of the PWM steering.
    localparam logic [1:0]      MODE_SINGLE   = 2'h0;
    localparam logic [1:0]      MODE_FULL_FWD = 2'h1;
    localparam logic [1:0]      MODE_HALF     = 2'h2;
    localparam logic [1:0]      MODE_FULL_REV = 2'h3;

    // Shutdown pin states; bit 1 set means tri-state.
    localparam logic [1:0]      SS_LOW        = 2'h0;
    localparam logic [1:0]      SS_HIGH       = 2'h1;
    localparam int              SS_TRI_BIT    = 1;

    // AXI responses.
    localparam logic [1:0]      RESP_OKAY     = 2'h0;
    localparam logic [1:0]      RESP_SLVERR   = 2'h2;

    // Dead-band and restart register.
    typedef struct packed {
        logic       autoRestartEn;
        logic [6:0] deadbandCount;
    } pasd_deadband_t;

    // Auto-shutdown control register.
    typedef struct packed {
        logic       shutdownStatus;
        logic [2:0] shutdownSourceSel;
        logic [1:0] pairAcShutdownState;
        logic [1:0] pairBdShutdownState;
    } pasd_shutdown_t;

    // Mode register: pin output enables (D,C,B,A), polarity (BD,AC), output mode.
    typedef struct packed {
        logic [3:0] pinDirection;
        logic [1:0] outputPolaritySel;
        logic [1:0] outputMode;
    } pasd_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } pasd_axi_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } pasd_axi_rsp_t;

    // Pin order is D,C,B,A; oeN low means the pin is driven.
    typedef struct packed {
        logic [3:0] pwmOut;
        logic [3:0] pwmOeN;
    } pasd_pins_t;

    typedef struct packed {
        logic              faultSync1;
        logic              faultSync2;
        logic              cmp1Sync1;
        logic              cmp1Sync2;
        logic              cmp2Sync1;
        logic              cmp2Sync2;
        pasd_deadband_t    deadband;
        pasd_shutdown_t    shutdown;
        pasd_mode_t        mode;
        logic              shutHold;
        logic [6:0]        dbCntA;
        logic [6:0]        dbCntB;
        pasd_pins_t        pins;
        logic              periodFlag;
        logic              awPend;
        logic [ADDR_W-1:0] awAddr;
        logic              wPend;
        logic [7:0]        wData;
        logic              wStrb0;
        pasd_axi_rsp_t     axi;
    } pasd_state_t;

endpackage

// ---- pwm_auto_shutdown_deadband.sv ----
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Auto-shutdown acts only in half-bridge or full-bridge output modes.
// - Three-bit source select picks comparator 1, comparator 2, fault pin, or combinations.
// - A low level on the selected fault input is a shutdown event.
// - Shutdown forces pins to shutdown states at once, not at a period boundary.
// - Pair A/C shutdown state: 00 low, 01 high, 1x tri-state.
// - Pair B/D shutdown state: 00 low, 01 high, 1x tri-state.
// - Hardware sets the status bit on shutdown; set status holds outputs shut.
// - With auto-restart, status stays while the cause lasts, then clears itself.
// - Status set at period start shuts whole period; resume only at next period.
// - Software writes to the status bit are ignored while a cause is active.
// - Comparator causes are levels; status cannot clear while they persist.
// - Software writing 1 to status forces shutdown like a hardware event.
// - Seven-bit count delays each active-going transition of outputs A and B by that many cycles.
// - Dead-band applies only in half-bridge mode, only on inactive-to-active edges.
// - The period flag is raised as each new PWM period begins.
module pwm_auto_shutdown_deadband (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire pasd_pkg::pasd_axi_req_t axiReq,
    output var  pasd_pkg::pasd_axi_rsp_t axiRsp,
    input  wire logic                   faultInN,
    input  wire logic                   cmp1Out,
    input  wire logic                   cmp2Out,
    input  wire logic                   periodStart,
    input  wire logic [3:0]             pwmRaw,
    output var  pasd_pkg::pasd_pins_t   pins,
    output logic                        periodTimerFlag
);
    import pasd_pkg::*;

    pasd_state_t st;
    pasd_state_t next_st;

    logic        enhanced;
    logic        cause;
    logic        doWrite;
    logic        wrMapped;
    logic        swStatusWr;
    logic        shutOut;
    logic        halfMode;
    logic [3:0]  active;
    logic [3:0]  level;
    logic [7:0]  rdByte;
    logic        rdMapped;

    // Next dead-band count: counts up while the raw output is active, clears when inactive.
    function automatic logic [6:0] dbNext(input logic raw, input logic [6:0] cnt, input logic [6:0] lim);
        logic [6:0] res;
        res = 7'h00;
        if (raw && (cnt < lim)) begin
            res = cnt + 7'h01;
        end else if (raw) begin
            res = cnt;
        end
        return res;
    endfunction

    // An output is active once its raw level has been active for the full count.
    // The caller passes the registered count, so a count of N gives exactly N cycles of delay.
    function automatic logic dbActive(input logic raw, input logic [6:0] cnt, input logic [6:0] lim);
        return raw && (cnt >= lim);
    endfunction

    // Register read decode shared by the read channel.
    function automatic logic [7:0] regRead(input pasd_state_t s, input logic [ADDR_W-1:0] a);
        logic [7:0] res;
        res = 8'h00;
        unique case (a)
            OFF_DEADBAND: res = s.deadband;
            OFF_SHUTDOWN: res = s.shutdown;
            OFF_MODE:     res = s.mode;
            OFF_STATUS:   res = {4'h0, s.shutHold, ~s.faultSync2, s.cmp2Sync2, s.cmp1Sync2};
            default:      res = 8'h00;
        endcase
        return res;
    endfunction

    // Address is mapped when it hits one of the four aligned words.
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return (a & ADDR_MASK) == '0 && a[1:0] == 2'h0;
    endfunction

    // Derived conditions of the current state.
    always_comb begin
        enhanced   = st.mode.outputMode != MODE_SINGLE;
        halfMode   = st.mode.outputMode == MODE_HALF;
        cause      = enhanced && (|(st.shutdown.shutdownSourceSel &
                     {~st.faultSync2, st.cmp2Sync2, st.cmp1Sync2}));
        doWrite    = st.awPend && st.wPend && !st.axi.bvalid;
        wrMapped   = isMapped(st.awAddr);
        swStatusWr = doWrite && st.wStrb0 && (st.awAddr == OFF_SHUTDOWN);
        rdMapped   = isMapped(axiReq.araddr);
        rdByte     = regRead(st, axiReq.araddr);
    end

    // Next-state logic for synchronisers, registers, shutdown, dead-band and bus.
    always_comb begin
        next_st = st;
        shutOut = 1'b0;
        active  = 4'h0;
        level   = 4'h0;

        // Pins from outside pass two flip-flops before use.
        next_st.faultSync1 = faultInN;
        next_st.faultSync2 = st.faultSync1;
        next_st.cmp1Sync1  = cmp1Out;
        next_st.cmp1Sync2  = st.cmp1Sync1;
        next_st.cmp2Sync1  = cmp2Out;
        next_st.cmp2Sync2  = st.cmp2Sync1;

        // Address and data are taken independently and held until both arrive.
        if (axiReq.awvalid && st.axi.awready) begin
            next_st.awPend = 1'b1;
            next_st.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && st.axi.wready) begin
            next_st.wPend  = 1'b1;
            next_st.wData  = axiReq.wdata[7:0];
            next_st.wStrb0 = axiReq.wstrb[0];
        end
        if (st.axi.bvalid && axiReq.bready) begin
            next_st.axi.bvalid = 1'b0;
        end
        if (doWrite) begin
            next_st.awPend     = 1'b0;
            next_st.wPend      = 1'b0;
            next_st.axi.bvalid = 1'b1;
            next_st.axi.bresp  = wrMapped ? RESP_OKAY : RESP_SLVERR;
            if (st.wStrb0) begin
                unique case (st.awAddr)
                    OFF_DEADBAND: next_st.deadband = st.wData;
                    OFF_SHUTDOWN: next_st.shutdown[6:0] = st.wData[6:0];
                    OFF_MODE:     next_st.mode = st.wData;
                    default:      next_st.mode = st.mode;
                endcase
            end
        end

        // Status bit: a live cause wins over any write or automatic clear.
        if (cause) begin
            next_st.shutdown.shutdownStatus = 1'b1;
        end else if (swStatusWr) begin
            next_st.shutdown.shutdownStatus = st.wData[7];
        end else if (st.deadband.autoRestartEn) begin
            next_st.shutdown.shutdownStatus = 1'b0;
        end

        // Hold shutdown from the status edge until a period starts with status clear.
        if (next_st.shutdown.shutdownStatus) begin
            next_st.shutHold = 1'b1;
        end else if (periodStart) begin
            next_st.shutHold = 1'b0;
        end
        shutOut = next_st.shutHold && enhanced;

        // Dead-band on A and B in half-bridge mode only.
        next_st.dbCntA = dbNext(pwmRaw[0], st.dbCntA, st.deadband.deadbandCount);
        next_st.dbCntB = dbNext(pwmRaw[1], st.dbCntB, st.deadband.deadbandCount);
        active = pwmRaw;
        if (halfMode) begin
            active[0] = dbActive(pwmRaw[0], st.dbCntA, st.deadband.deadbandCount);
            active[1] = dbActive(pwmRaw[1], st.dbCntB, st.deadband.deadbandCount);
        end

        // Polarity per pair: bit 0 inverts A and C, bit 1 inverts B and D.
        level = active ^ {st.mode.outputPolaritySel[1], st.mode.outputPolaritySel[0],
                          st.mode.outputPolaritySel[1], st.mode.outputPolaritySel[0]};
        next_st.pins.pwmOut = level;
        next_st.pins.pwmOeN = ~st.mode.pinDirection;
        if (shutOut) begin
            next_st.pins.pwmOut = {st.shutdown.pairBdShutdownState[0], st.shutdown.pairAcShutdownState[0],
                                   st.shutdown.pairBdShutdownState[0], st.shutdown.pairAcShutdownState[0]};
            next_st.pins.pwmOeN = ~st.mode.pinDirection |
                                  {st.shutdown.pairBdShutdownState[SS_TRI_BIT],
                                   st.shutdown.pairAcShutdownState[SS_TRI_BIT],
                                   st.shutdown.pairBdShutdownState[SS_TRI_BIT],
                                   st.shutdown.pairAcShutdownState[SS_TRI_BIT]};
        end

        // Period flag follows the period start by one cycle.
        next_st.periodFlag = periodStart;

        // Read channel: one read at a time, data registered with the answer.
        if (st.axi.rvalid && axiReq.rready) begin
            next_st.axi.rvalid = 1'b0;
        end
        if (axiReq.arvalid && st.axi.arready) begin
            next_st.axi.rvalid = 1'b1;
            next_st.axi.rdata  = {24'h000000, rdByte};
            next_st.axi.rresp  = rdMapped ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.axi.arready = !next_st.axi.rvalid;
        next_st.axi.awready = !next_st.awPend && !next_st.axi.bvalid;
        next_st.axi.wready  = !next_st.wPend && !next_st.axi.bvalid;
    end

    // All state registers; reset clears every field.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register.
    assign axiRsp          = st.axi;
    assign pins            = st.pins;
    assign periodTimerFlag = st.periodFlag;

    // Checks on shutdown, restart, dead-band and bus behaviour.
    default clocking cbClk @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_cause_sets_status: assert property (
        cause |=> st.shutdown.shutdownStatus && st.shutHold)
        else $error("Shutdown cause did not set status.");

    a_write_ignored_active: assert property (
        (cause && swStatusWr && !st.wData[7]) |=> st.shutdown.shutdownStatus)
        else $error("Status cleared by write during active cause.");

    a_manual_status_hold: assert property (
        (st.shutdown.shutdownStatus && !st.deadband.autoRestartEn && !swStatusWr)
        |=> st.shutdown.shutdownStatus)
        else $error("Status cleared without software in manual mode.");

    a_auto_restart_clear: assert property (
        (st.shutdown.shutdownStatus && st.deadband.autoRestartEn && !cause && !swStatusWr)
        |=> !st.shutdown.shutdownStatus)
        else $error("Auto-restart did not clear status.");

    a_force_by_write: assert property (
        (swStatusWr && st.wData[7]) |=> st.shutdown.shutdownStatus && st.shutHold)
        else $error("Writing one to status did not force shutdown.");

    a_hold_whole_period: assert property (
        (st.shutHold && !periodStart) |=> st.shutHold)
        else $error("Shutdown released before a period start.");

    a_resume_at_period: assert property (
        $fell(st.shutHold) |-> $past(periodStart) && !st.shutdown.shutdownStatus)
        else $error("Outputs resumed away from a period start.");

    a_shutdown_pin_level: assert property (
        ($rose(st.shutHold) && $past(enhanced) && $stable(st.shutdown.pairAcShutdownState)
         && !st.shutdown.pairAcShutdownState[SS_TRI_BIT] && $stable(st.mode))
        |-> st.pins.pwmOut[0] == st.shutdown.pairAcShutdownState[0] && st.pins.pwmOut[2] == st.pins.pwmOut[0])
        else $error("Pair A/C not at programmed shutdown level.");

    a_deadband_inactive: assert property (
        (halfMode && $stable(st.mode) && $stable(st.deadband) && !st.shutHold
         && st.dbCntA < st.deadband.deadbandCount)
        |-> st.pins.pwmOut[0] == st.mode.outputPolaritySel[0])
        else $error("Output A went active inside the dead band.");

    a_period_flag_pulse: assert property (
        periodStart |=> periodTimerFlag)
        else $error("Period flag missing after period start.");

    a_write_response: assert property (
        doWrite |=> axiRsp.bvalid ##0 (axiRsp.bresp == RESP_OKAY) == $past(wrMapped))
        else $error("Write response missing or wrong.");

endmodule

`default_nettype wire

// ---- pasd_bridge_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Bridge gate-driver inputs: a pad that is not driven is pulled low so its switch stays off.
module pasd_bridge_model (
    input  wire pasd_pkg::pasd_pins_t pins,
    output logic [3:0]                padLevel
);
    import pasd_pkg::*;

    // Resolves each pad from the driven level or the pull-down.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            padLevel[i] = pins.pwmOeN[i] ? 1'b0 : pins.pwmOut[i];
        end
    end
endmodule

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import pasd_pkg::*;

    logic          clk;
    logic          resetn;
    pasd_axi_req_t axiReq;
    pasd_axi_rsp_t axiRsp;
    logic [2:0]    causeV;
    wire logic     faultInN;
    wire logic     cmp1Out;
    wire logic     cmp2Out;
    logic          periodStart;
    logic [3:0]    pwmRaw;
    pasd_pins_t    pins;
    logic          periodTimerFlag;
    logic [3:0]    padLevel;
    logic [1:0]    ac;
    logic [1:0]    bd;
    logic [3:0]    fv;
    logic [7:0]    ex;
    logic          hit;
    int            miscompares;
    int            checked;
    int            seed;
    int            n;
    int            d;
    int            delayQ [$];

    // Causes as levels: comparators high-active, fault pin low-active.
    assign cmp1Out  = causeV[0];
    assign cmp2Out  = causeV[1];
    assign faultInN = ~causeV[2];

    pwm_auto_shutdown_deadband pwm_auto_shutdown_deadband_inst (
        .clk             (clk),
        .resetn          (resetn),
        .axiReq          (axiReq),
        .axiRsp          (axiRsp),
        .faultInN        (faultInN),
        .cmp1Out         (cmp1Out),
        .cmp2Out         (cmp2Out),
        .periodStart     (periodStart),
        .pwmRaw          (pwmRaw),
        .pins            (pins),
        .periodTimerFlag (periodTimerFlag)
    );

    pasd_bridge_model pasd_bridge_model_inst (
        .pins     (pins),
        .padLevel (padLevel)
    );

    // Bench clock of 25 ns.
    always #12.5 clk = ~clk;

    // Counts a comparison and reports a mismatch at once.
    task automatic cmpVal(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // AXI4-Lite write; address and data are offered together, each released once taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
        int k;
        k = 0;
        axiReq.awaddr  <= a;
        axiReq.awvalid <= 1'b1;
        axiReq.wdata   <= {24'h0, v};
        axiReq.wstrb   <= 4'hf;
        axiReq.wvalid  <= 1'b1;
        axiReq.bready  <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (axiReq.awvalid && axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
        end while (axiRsp.bvalid !== 1'b1 && k < 200);
        axiReq.bready <= 1'b0;
        if (k >= 200) miscompares++;
        cmpVal("bresp", {30'h0, r}, {30'h0, axiRsp.bresp});
        @(posedge clk);
    endtask

    // AXI4-Lite read; the whole 32-bit word is compared.
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
        int k;
        k = 0;
        axiReq.araddr  <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready  <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (axiReq.arvalid && axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
        end while (axiRsp.rvalid !== 1'b1 && k < 200);
        axiReq.rready <= 1'b0;
        if (k >= 200) miscompares++;
        cmpVal("rdata", {24'h0, e}, axiRsp.rdata);
        cmpVal("rresp", {30'h0, r}, {30'h0, axiRsp.rresp});
        @(posedge clk);
    endtask

    // Period start pulse; the flag follows one cycle later for one cycle.
    task automatic pulse();
        periodStart <= 1'b1;
        @(posedge clk);
        periodStart <= 1'b0;
        @(posedge clk);
        cmpVal("flag", 32'h1, {31'h0, periodTimerFlag});
        @(posedge clk);
        cmpVal("flag", 32'h0, {31'h0, periodTimerFlag});
    endtask

    // Edges from a change of the raw A input until pins.pwmOut[0] shows it.
    task automatic measure(input logic lvl);
        pwmRaw[0] <= lvl;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pins.pwmOut[0] !== lvl && n < 300);
        cmpVal("delay", 32'(delayQ.pop_front()), 32'(n));
    endtask

    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        seed = 32'h280d;
        clk = 1'b0;
        resetn = 1'b0;
        axiReq = '0;
        causeV = 3'h0;
        periodStart = 1'b0;
        pwmRaw = 4'h0;
        miscompares = 0;
        checked = 0;
        tick(10);
        resetn <= 1'b1;
        tick(2);
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 8'h00, RESP_OKAY);
        rd(8'h20, 8'h00, RESP_SLVERR);
        wr(8'h20, 8'h55, RESP_SLVERR);
        // Pins stay undriven through one full period before they are enabled.
        wr(OFF_MODE, 8'h02, RESP_OKAY);
        pulse();
        pulse();
        wr(OFF_MODE, 8'hf2, RESP_OKAY);
        wr(OFF_DEADBAND, 8'h80, RESP_OKAY);
        // Every source code against every cause, pin states varied alongside.
        for (int s = 0; s < 8; s++) begin
            for (int c = 0; c < 3; c++) begin
                ac = 2'(s + c);
                bd = 2'(s - c);
                hit = 1'((s >> c) & 1);
                pwmRaw <= 4'($random(seed));
                wr(OFF_SHUTDOWN, {1'b0, 3'(s), ac, bd}, RESP_OKAY);
                causeV[c] <= 1'b1;
                tick(6);
                rd(OFF_SHUTDOWN, {hit, 3'(s), ac, bd}, RESP_OKAY);
                rd(OFF_STATUS, {4'h0, hit, 3'(1 << c)}, RESP_OKAY);
                fv = {~bd[1] & bd[0], ~ac[1] & ac[0], ~bd[1] & bd[0], ~ac[1] & ac[0]};
                ex = hit ? {bd[1], ac[1], bd[1], ac[1], fv} : {4'h0, pwmRaw};
                cmpVal("pins", {24'h0, ex}, {24'h0, pins.pwmOeN, padLevel});
                causeV[c] <= 1'b0;
                tick(6);
                rd(OFF_SHUTDOWN, {1'b0, 3'(s), ac, bd}, RESP_OKAY);
                cmpVal("held", {24'h0, ex}, {24'h0, pins.pwmOeN, padLevel});
                pulse();
                cmpVal("resume", {28'h0, pwmRaw}, {28'h0, padLevel});
            end
        end
        // Without restart the status stays until software clears it.
        pwmRaw <= 4'hf;
        wr(OFF_DEADBAND, 8'h00, RESP_OKAY);
        wr(OFF_SHUTDOWN, 8'h40, RESP_OKAY);
        causeV[2] <= 1'b1;
        tick(6);
        wr(OFF_SHUTDOWN, 8'h40, RESP_OKAY);
        rd(OFF_SHUTDOWN, 8'hc0, RESP_OKAY);
        causeV[2] <= 1'b0;
        tick(6);
        rd(OFF_SHUTDOWN, 8'hc0, RESP_OKAY);
        wr(OFF_SHUTDOWN, 8'h40, RESP_OKAY);
        rd(OFF_SHUTDOWN, 8'h40, RESP_OKAY);
        pulse();
        wr(OFF_SHUTDOWN, 8'hc0, RESP_OKAY);
        rd(OFF_SHUTDOWN, 8'hc0, RESP_OKAY);
        cmpVal("forced", 32'h0, {28'h0, padLevel});
        wr(OFF_SHUTDOWN, 8'h40, RESP_OKAY);
        pulse();
        // Single output mode ignores the fault.
        wr(OFF_MODE, 8'hf0, RESP_OKAY);
        causeV[2] <= 1'b1;
        tick(6);
        rd(OFF_SHUTDOWN, 8'h40, RESP_OKAY);
        cmpVal("single", 32'h1, {31'h0, padLevel[0]});
        causeV[2] <= 1'b0;
        // Dead-band: rising edges delayed in half-bridge only, falling edges never.
        for (int j = 0; j < 2; j++) begin
            d = (j == 0) ? ($random(seed) & 63) : 127;
            wr(OFF_MODE, 8'hf2, RESP_OKAY);
            wr(OFF_DEADBAND, 8'(d), RESP_OKAY);
            pwmRaw <= 4'h0;
            tick(4);
            delayQ.push_back(d + 2);
            measure(1'b1);
            delayQ.push_back(2);
            measure(1'b0);
            wr(OFF_MODE, (j == 0) ? 8'hf1 : 8'hf3, RESP_OKAY);
            delayQ.push_back(2);
            measure(1'b1);
        end
        results();
    end

    // Cuts a hung run short, far beyond the expected length.
    initial begin
        #(25 * 40000);
        miscompares++;
        results();
    end
endmodule

`default_nettype wire
